// file: design/gcm_bus_mgr.sv
`timescale 1ns/1ps
`default_nettype none

module gcm_bus_mgr
    import gcm_pkg::*;
#(
    parameter int IFC_CYC = IFC_CYC_DEF
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // configuration strap
    input wire logic sys_ctrl_strap,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // bus lines, true level
    input wire gcm_bus_in_t bus_i,
    output gcm_bus_out_t bus_o
);

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_IFC, ST_SEND, ST_WAIT, ST_READ, ST_PARALLEL_STATUS_POLL, ST_DONE
    } gcm_st_t;

    typedef struct packed {
        gcm_st_t st;
        logic init_done;
        logic sys;
        logic active;
        logic [4:0] own_addr;
        logic err;
        logic ren;
        logic atn;
        logic ifc;
        logic eoi;
        logic [7:0] dio;
        logic dio_oe;
        logic nrfd;
        logic ndac;
        gcm_seq_t seq;
        logic [2:0] idx;
        logic got;
        gcm_op_t op;
        logic [7:0] result;
        logic [TMR_W-1:0] timer;
        logic snd_start;
        logic snd_cancel;
        logic [31:0] rdata;
    } gcm_state_t;

    gcm_state_t s_r;
    gcm_state_t s_nxt;
    logic snd_done;
    logic snd_dav;

    // -------------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------------
    function automatic logic role_ok(gcm_op_t op, logic adrd, logic sys, logic act);
        logic ok;
        ok = 1'b0;
        case (op)
            OP_REMOTE: ok = sys;
            OP_LOCAL: ok = adrd ? act : sys;
            OP_ABORT: ok = (act | sys) & ~adrd;
            OP_BAD: ok = 1'b0;
            default: ok = act;
        endcase
        return ok;
    endfunction

    function automatic logic [7:0] with_addr(logic [7:0] base, logic [4:0] a);
        return base | {3'h0, a};
    endfunction

    // builds the command bytes of one request, first byte in slot 0
    function automatic gcm_seq_t build_seq(gcm_op_t op, logic adrd, logic [4:0] a,
                                           logic [4:0] own, logic [7:0] raw);
        gcm_seq_t q;
        q = '0;
        case (op)
            OP_UNTALK: begin
                q.list[0] = CMD_UNT;
                q.cnt = 3'h1;
            end
            OP_UNLISTEN: begin
                q.list[0] = CMD_UNL;
                q.cnt = 3'h1;
            end
            OP_TALK: begin
                q.list[0] = with_addr(TALK_BASE, a);
                q.cnt = 3'h1;
            end
            OP_LISTEN: begin
                q.list[0] = with_addr(LISTEN_BASE, a);
                q.cnt = 3'h1;
            end
            OP_SECONDARY: begin
                q.list[0] = with_addr(SEC_BASE, a);
                q.cnt = 3'h1;
            end
            OP_REMOTE: begin
                // being addressed is what moves the device to remote
                q.list[0] = CMD_UNL;
                q.list[1] = with_addr(LISTEN_BASE, a);
                q.cnt = adrd ? 3'h2 : 3'h0;
            end
            OP_LLO: begin
                q.list[0] = CMD_LLO;
                q.cnt = 3'h1;
            end
            OP_LOCAL, OP_TRIGGER, OP_CLEAR: begin
                q.list[0] = CMD_UNL;
                q.list[1] = with_addr(LISTEN_BASE, a);
                q.list[2] = (op == OP_LOCAL) ? CMD_GTL : (op == OP_TRIGGER) ? CMD_GET : CMD_SDC;
                q.cnt = 3'h3;
                if (!adrd) begin
                    // unaddressed trigger reuses the listeners already set up
                    q.list[0] = (op == OP_TRIGGER) ? CMD_GET : CMD_DCL;
                    q.cnt = (op == OP_LOCAL) ? 3'h0 : 3'h1;
                end
            end
            OP_PASS: begin
                q.list[0] = with_addr(TALK_BASE, a);
                q.list[1] = CMD_TCT;
                q.cnt = 3'h2;
            end
            OP_SERIAL_STATUS_POLL: begin
                q.list[0] = CMD_UNL;
                q.list[1] = with_addr(TALK_BASE, a);
                q.list[2] = with_addr(LISTEN_BASE, own);
                q.list[3] = CMD_SPE;
                q.list[4] = CMD_SPD;
                q.list[5] = CMD_UNT;
                q.cnt = 3'h6;
                q.read_at = 3'h4;
                q.do_read = 1'b1;
            end
            OP_RAW: begin
                q.list[0] = raw;
                q.cnt = 3'h1;
            end
            default: begin
                q.cnt = 3'h0;
            end
        endcase
        return q;
    endfunction

    // -------------------------------------------------------------------
    // sequencer and register port
    // -------------------------------------------------------------------
    always_comb begin
        gcm_op_t wop;
        logic wadrd;
        logic [4:0] waddr;
        wop = gcm_op_t'(reg_wdata[CMD_OP_LSB +: 4]);
        wadrd = reg_wdata[CMD_ADRD_BIT];
        waddr = reg_wdata[CMD_ADDR_LSB +: 5];
        s_nxt = s_r;
        s_nxt.snd_start = 1'b0;
        s_nxt.snd_cancel = 1'b0;

        // strap caught on the first edge after reset release
        if (!s_r.init_done) begin
            s_nxt.init_done = 1'b1;
            s_nxt.sys = sys_ctrl_strap;
            s_nxt.active = sys_ctrl_strap;
            s_nxt.ren = sys_ctrl_strap;
        end

        case (s_r.st)
            ST_IDLE: begin
            end
            ST_IFC: begin
                s_nxt.timer = s_r.timer + 1'b1;
                if (s_r.timer == TMR_W'(IFC_CYC - 1)) begin
                    s_nxt.ifc = 1'b0;
                    s_nxt.active = 1'b1;
                    if (s_r.sys) begin
                        s_nxt.ren = 1'b1;
                    end
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_SEND: begin
                if (s_r.idx == s_r.seq.cnt) begin
                    s_nxt.st = ST_DONE;
                end else if (s_r.seq.do_read && s_r.idx == s_r.seq.read_at && !s_r.got) begin
                    s_nxt.atn = 1'b0;
                    s_nxt.dio_oe = 1'b0;
                    s_nxt.ndac = 1'b1;
                    s_nxt.nrfd = 1'b0;
                    s_nxt.st = ST_READ;
                end else begin
                    s_nxt.atn = 1'b1;
                    s_nxt.dio = s_r.seq.list[s_r.idx];
                    s_nxt.dio_oe = 1'b1;
                    s_nxt.snd_start = 1'b1;
                    s_nxt.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (snd_done) begin
                    s_nxt.idx = s_r.idx + 1'b1;
                    s_nxt.st = ST_SEND;
                end
            end
            ST_READ: begin
                if (!s_r.got && bus_i.dav) begin
                    s_nxt.result = bus_i.dio;
                    s_nxt.got = 1'b1;
                    s_nxt.nrfd = 1'b1;
                    s_nxt.ndac = 1'b0;
                end else if (s_r.got && !bus_i.dav) begin
                    s_nxt.nrfd = 1'b0;
                    s_nxt.st = ST_SEND;
                end
            end
            ST_PARALLEL_STATUS_POLL: begin
                s_nxt.timer = s_r.timer + 1'b1;
                if (s_r.timer == TMR_W'(PARALLEL_STATUS_POLL_CYC - 1)) begin
                    s_nxt.result = bus_i.dio;
                    s_nxt.eoi = 1'b0;
                    s_nxt.st = ST_DONE;
                end
            end
            ST_DONE: begin
                s_nxt.atn = 1'b0;
                s_nxt.dio_oe = 1'b0;
                if (s_r.op == OP_PASS) begin
                    s_nxt.active = 1'b0;
                end
                s_nxt.st = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: begin
                    s_nxt.rdata = '0;
                    s_nxt.rdata[ST_SYS_BIT] = s_r.sys;
                    s_nxt.rdata[ST_ACT_BIT] = s_r.active;
                    s_nxt.rdata[ST_BUSY_BIT] = (s_r.st != ST_IDLE);
                    s_nxt.rdata[ST_ERR_BIT] = s_r.err;
                    s_nxt.rdata[ST_REN_BIT] = s_r.ren;
                end
                REG_OWN: s_nxt.rdata = {27'h0, s_r.own_addr};
                REG_RESULT: s_nxt.rdata = {24'h0, s_r.result};
                default: s_nxt.rdata = '0;
            endcase
        end

        if (reg_wr) begin
            case (reg_addr)
                REG_STATUS: begin
                    if (reg_wdata[ST_ERR_BIT]) begin
                        s_nxt.err = 1'b0;
                    end
                end
                REG_OWN: s_nxt.own_addr = reg_wdata[4:0];
                REG_CMD: begin
                    if (!role_ok(wop, wadrd, s_r.sys, s_r.active)) begin
                        s_nxt.err = 1'b1;
                    end else if (wop == OP_ABORT) begin
                        // abort overrides whatever transfer is in flight
                        s_nxt.snd_cancel = 1'b1;
                        s_nxt.ifc = 1'b1;
                        s_nxt.atn = 1'b0;
                        s_nxt.eoi = 1'b0;
                        s_nxt.dio_oe = 1'b0;
                        s_nxt.nrfd = 1'b0;
                        s_nxt.ndac = 1'b0;
                        s_nxt.timer = '0;
                        s_nxt.op = wop;
                        s_nxt.st = ST_IFC;
                    end else if (s_r.st != ST_IDLE) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.op = wop;
                        s_nxt.seq = build_seq(wop, wadrd, waddr, s_r.own_addr,
                                              reg_wdata[CMD_RAW_LSB +: 8]);
                        s_nxt.idx = '0;
                        s_nxt.got = 1'b0;
                        if (wop == OP_REMOTE) begin
                            s_nxt.ren = 1'b1;
                        end
                        if (wop == OP_LOCAL && !wadrd) begin
                            // dropping remote enable also ends any lockout
                            s_nxt.ren = 1'b0;
                        end
                        if (wop == OP_PARALLEL_STATUS_POLL) begin
                            s_nxt.atn = 1'b1;
                            s_nxt.eoi = 1'b1;
                            s_nxt.dio_oe = 1'b0;
                            s_nxt.timer = '0;
                            s_nxt.st = ST_PARALLEL_STATUS_POLL;
                        end else begin
                            s_nxt.st = ST_SEND;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.op <= OP_UNTALK;
            s_r.own_addr <= OWN_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // -------------------------------------------------------------------
    // byte source handshake
    // -------------------------------------------------------------------
    gcm_src_hs u_src (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(s_r.snd_start),
        .cancel(s_nxt.snd_cancel), // dav must drop on the same edge that raises ifc
        .done(snd_done),
        .nrfd_i(bus_i.nrfd),
        .ndac_i(bus_i.ndac),
        .dav(snd_dav)
    );

    assign reg_rdata = s_r.rdata;
    assign bus_o = '{atn: s_r.atn, ifc: s_r.ifc, ren: s_r.ren, eoi: s_r.eoi,
                     dio: s_r.dio, dio_oe: s_r.dio_oe, dav: snd_dav,
                     nrfd: s_r.nrfd, ndac: s_r.ndac};

endmodule

`default_nettype wire

// file: design/gcm_pkg.sv
package gcm_pkg;

    // -------------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int PARALLEL_STATUS_POLL_NS = 2000;
    localparam int PARALLEL_STATUS_POLL_CYC = (PARALLEL_STATUS_POLL_NS * CLK_MHZ + 999) / 1000;
    localparam int IFC_US = 100;
    localparam int IFC_CYC_DEF = IFC_US * CLK_MHZ;
    localparam int SET_W = 7;
    localparam int TMR_W = 13;

    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam int AW = 8;
    localparam logic [AW-1:0] REG_STATUS = 8'h00;
    localparam logic [AW-1:0] REG_OWN = 8'h04;
    localparam logic [AW-1:0] REG_CMD = 8'h08;
    localparam logic [AW-1:0] REG_RESULT = 8'h0c;
    localparam int ST_SYS_BIT = 0;
    localparam int ST_ACT_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_ERR_BIT = 3;
    localparam int ST_REN_BIT = 4;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ADRD_BIT = 4;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_RAW_LSB = 16;
    localparam logic [4:0] OWN_RST = 5'h00;

    // -------------------------------------------------------------------
    // bus command bytes
    // -------------------------------------------------------------------
    localparam logic [7:0] CMD_UNL = 8'h3f;
    localparam logic [7:0] CMD_UNT = 8'h5f;
    localparam logic [7:0] TALK_BASE = 8'h40;
    localparam logic [7:0] LISTEN_BASE = 8'h20;
    localparam logic [7:0] SEC_BASE = 8'h60;
    localparam logic [7:0] CMD_LLO = 8'h11;
    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CMD_GET = 8'h08;
    localparam logic [7:0] CMD_DCL = 8'h14;
    localparam logic [7:0] CMD_SDC = 8'h04;
    localparam logic [7:0] CMD_TCT = 8'h09;
    localparam logic [7:0] CMD_SPE = 8'h18;
    localparam logic [7:0] CMD_SPD = 8'h19;

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_UNTALK, OP_UNLISTEN, OP_TALK, OP_LISTEN, OP_SECONDARY, OP_REMOTE,
        OP_LLO, OP_LOCAL, OP_TRIGGER, OP_CLEAR, OP_ABORT, OP_PASS,
        OP_PARALLEL_STATUS_POLL, OP_SERIAL_STATUS_POLL, OP_RAW, OP_BAD
    } gcm_op_t;

    typedef struct packed {
        logic [7:0] dio;
        logic dav;
        logic nrfd;
        logic ndac;
    } gcm_bus_in_t;

    typedef struct packed {
        logic atn;
        logic ifc;
        logic ren;
        logic eoi;
        logic [7:0] dio;
        logic dio_oe;
        logic dav;
        logic nrfd;
        logic ndac;
    } gcm_bus_out_t;

    typedef struct packed {
        logic [5:0][7:0] list;
        logic [2:0] cnt;
        logic [2:0] read_at;
        logic do_read;
    } gcm_seq_t;

endpackage

// file: design/gcm_src_hs.sv
`timescale 1ns/1ps
`default_nettype none

module gcm_src_hs
    import gcm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic start,
    input wire logic cancel,
    output logic done,
    // handshake lines, true level
    input wire logic nrfd_i,
    input wire logic ndac_i,
    output logic dav
);

    typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_READY, SH_ACK} gcm_sh_st_t;

    typedef struct packed {
        gcm_sh_st_t st;
        logic dav;
        logic done;
        logic [SET_W-1:0] timer;
    } gcm_sh_t;

    gcm_sh_t s_r;
    gcm_sh_t s_nxt;

    // -------------------------------------------------------------------
    // three-wire source handshake
    // -------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            SH_IDLE: begin
                if (start) begin
                    s_nxt.timer = '0;
                    s_nxt.st = SH_SETTLE;
                end
            end
            // data and attention must settle before valid is raised
            SH_SETTLE: begin
                s_nxt.timer = s_r.timer + 1'b1;
                if (s_r.timer == SET_W'(SETTLE_CYC - 1)) begin
                    s_nxt.st = SH_READY;
                end
            end
            SH_READY: begin
                if (!nrfd_i) begin
                    s_nxt.dav = 1'b1;
                    s_nxt.st = SH_ACK;
                end
            end
            SH_ACK: begin
                if (!ndac_i) begin
                    s_nxt.dav = 1'b0;
                    s_nxt.done = 1'b1;
                    s_nxt.st = SH_IDLE;
                end
            end
            default: begin
                s_nxt.st = SH_IDLE;
            end
        endcase
        if (cancel) begin
            s_nxt.st = SH_IDLE;
            s_nxt.dav = 1'b0;
            s_nxt.done = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '{st: SH_IDLE, dav: 1'b0, done: 1'b0, timer: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
    assign dav = s_r.dav;

endmodule

`default_nettype wire

// file: verification/gcm_bus_mgr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gcm_bus_mgr_checker
    import gcm_pkg::*;
#(
    parameter int IFC_CYC = 8
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // strap and register port
    input wire logic sys_ctrl_strap,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // bus lines
    input wire gcm_bus_in_t bus_i,
    input wire gcm_bus_out_t bus_o
);
    // ----
    // helper state
    // ----
    logic rst_d, sys_q;
    logic [4:0] own_q;
    int ifc_n;
    always_ff @(posedge sys_clk) begin
        rst_d <= sys_rst;
        // strap is caught once, at the first edge after release
        if (rst_d && !sys_rst) begin
            sys_q <= sys_ctrl_strap;
        end
        if (sys_rst) begin
            own_q <= OWN_RST;
            ifc_n <= 0;
        end else begin
            ifc_n <= bus_o.ifc ? ifc_n + 1 : 0;
            if (reg_wr && reg_addr == REG_OWN) begin
                own_q <= reg_wdata[4:0];
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----
    // assertions
    // ----
    own_read_a: assert property (reg_rd && reg_addr == REG_OWN |=>
        reg_rdata == {27'h0, own_q}) else $error("own address read wrong");
    sys_bit_a: assert property (reg_rd && reg_addr == REG_STATUS |=>
        reg_rdata[ST_SYS_BIT] == sys_q) else $error("system bit wrong");
    cmd_atn_a: assert property (bus_o.dav |-> bus_o.atn && bus_o.dio_oe)
        else $error("byte sent without attention");
    dio_hold_a: assert property (bus_o.dav && $past(bus_o.dav) |-> $stable(bus_o.dio))
        else $error("data moved under dav");
    dav_ready_a: assert property ($rose(bus_o.dav) |-> !$past(bus_i.nrfd))
        else $error("dav before ready");
    ifc_len_a: assert property ($fell(bus_o.ifc) |-> ifc_n == IFC_CYC)
        else $error("clear pulse length wrong");
    ifc_quiet_a: assert property (bus_o.ifc |-> !bus_o.atn && !bus_o.dio_oe && !bus_o.dav)
        else $error("bus busy during clear");
    ren_abort_a: assert property ($fell(bus_o.ifc) && sys_q |-> ##[0:3] bus_o.ren)
        else $error("remote not raised after abort");
    non_sys_quiet_a: assert property (!sys_q |-> !bus_o.ifc && !bus_o.ren && !bus_o.atn)
        else $error("bus touched without role");
    poll_atn_a: assert property (bus_o.eoi |-> bus_o.atn && !bus_o.dio_oe)
        else $error("poll without attention");
    cover property ($rose(bus_o.ifc));
    cover property ($rose(bus_o.eoi));
    cover property ($rose(bus_i.dav) && !bus_o.atn);
endmodule
bind gcm_bus_mgr gcm_bus_mgr_checker #(.IFC_CYC(IFC_CYC)) chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sys_ctrl_strap(sys_ctrl_strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_i(bus_i), .bus_o(bus_o)
);
`default_nettype wire

// file: verification/gcm_far_node.sv
`timescale 1ns/1ps
`default_nettype none
module gcm_far_node
    import gcm_pkg::*;
#(
    parameter logic [7:0] PP = 8'ha6,
    parameter logic [7:0] SB = 8'h41
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // controller lines and pacing
    input wire gcm_bus_out_t bo,
    input wire logic [7:0] wait_n,
    // our open-drain lines, true level
    output logic [7:0] dio,
    output logic dav,
    output logic nrfd,
    output logic ndac,
    // accepted command byte
    output logic got,
    output logic [7:0] gb
);
    logic rmt, lock;
    logic [7:0] w;
    // released lines fall to the pull-up, 0 in true level
    assign dio = (bo.atn && bo.eoi) ? PP : (dav ? SB : 8'h00);
    always_ff @(posedge sys_clk) begin
        got <= 1'b0;
        if (sys_rst) begin
            {dav, nrfd, w, rmt, lock} <= '0;
            ndac <= 1'b1;
        end else if (bo.dav && bo.atn && ndac) begin
            // slow listener holds off acceptance
            if (w == wait_n) begin
                {got, gb, ndac, nrfd, w} <= {1'b1, bo.dio, 2'b01, 8'h00};
                rmt <= rmt | (bo.dio[7:5] == 3'h1 && bo.dio != CMD_UNL);
                lock <= lock | (bo.dio == CMD_LLO);
            end else begin
                w <= w + 8'h01;
            end
        end else begin
            w <= 8'h00;
            if (!bo.dav) begin
                {ndac, nrfd} <= 2'b10;
            end
            if (!bo.atn && bo.ndac && !bo.nrfd) begin
                dav <= 1'b1;
            end else if (!bo.ndac) begin
                dav <= 1'b0;
            end
        end
        // dropping remote enable returns every device to local
        if (!bo.ren) begin
            {rmt, lock} <= 2'b00;
        end
    end
endmodule
`default_nettype wire

// file: verification/gcm_bus_mgr_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gcm_bus_mgr_tb
    import gcm_pkg::*;
;
    logic sys_clk, sys_rst, strap, wr, rd, p_dav, p_nrfd, p_ndac, got;
    logic [7:0] ra, wn, p_dio, gb;
    logic [31:0] wd, rdata, v;
    gcm_bus_in_t bi;
    gcm_bus_out_t bo;
    logic [7:0] q[$];
    int failures, comparisons;
    // op with addressed bit, expected bytes, byte count
    logic [4:0] to[13] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h11,
        5'h12, 5'h13, 5'h0f, 5'h0b, 5'h1c};
    logic [23:0] te[13] = '{24'h5f, 24'h3f, 24'h45, 24'h25, 24'h65, 24'h11, 24'h08,
        24'h3f2508, 24'h14, 24'h3f2504, 24'h3f2501, 24'h3f25, 24'h5a};
    int tn[13] = '{1, 1, 1, 1, 1, 1, 1, 3, 1, 3, 3, 2, 1};
    assign bi = {(bo.dio_oe ? bo.dio : 8'h00) | p_dio, bo.dav | p_dav, bo.nrfd | p_nrfd,
        bo.ndac | p_ndac};
    gcm_bus_mgr #(.IFC_CYC(8)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .sys_ctrl_strap(strap), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .bus_i(bi), .bus_o(bo));
    gcm_far_node far (.sys_clk(sys_clk), .sys_rst(sys_rst), .bo(bo), .wait_n(wn),
        .dio(p_dio), .dav(p_dav), .nrfd(p_nrfd), .ndac(p_ndac), .got(got), .gb(gb));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (got) begin
            q.push_back(gb);
        end
    end
    // ----
    // tasks
    // ----
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr_r(input logic [7:0] a, input logic [31:0] d);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd_r(input logic [7:0] a);
        ra <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
        @(posedge sys_clk);
    endtask
    task idle();
        rd_r(REG_STATUS);
        for (int i = 0; i < 3000 && v[ST_BUSY_BIT] !== 1'b0; i++) begin
            rd_r(REG_STATUS);
        end
        chk(v[ST_BUSY_BIT], 1'b0);
    endtask
    function logic [31:0] cw(input logic [3:0] op, input logic ad, input logic [4:0] a);
        return {8'h00, 8'h5a, 3'h0, a, 3'h0, ad, op};
    endfunction
    task run(input logic [31:0] c, input logic [63:0] e, input int n);
        q.delete();
        wr_r(REG_CMD, c);
        idle();
        chk(q.size(), n);
        for (int i = 0; i < n; i++) begin
            chk(q[i], e[8*(n-1-i) +: 8]);
        end
    endtask
    task st(input logic [31:0] e);
        rd_r(REG_STATUS);
        chk(v, e);
    endtask
    task boot(input logic s);
        sys_rst <= 1'b1;
        strap <= s;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task test_done();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        {sys_rst, strap, wr, rd, ra, wd, wn} = {4'h8, 8'h00, 32'h0, 8'h00};
        failures = 0;
        comparisons = 0;
        boot(1'b0);
        st(32'h00);
        run(cw(4'h0, 1'b0, 5'h05), 64'h0, 0);
        run(cw(4'h5, 1'b0, 5'h05), 64'h0, 0);
        run(cw(4'ha, 1'b0, 5'h05), 64'h0, 0);
        st(32'h08);
        boot(1'b1);
        st(32'h13);
        rd_r(REG_OWN);
        chk(v, 32'h0);
        wr_r(REG_OWN, 32'h1e);
        rd_r(REG_OWN);
        chk(v, 32'h1e);
        rd_r(8'h20);
        chk(v, 32'h0);
        // each of the 13 table entries twice: prompt listener, then a slow one
        for (int s = 0; s < 2; s++) begin
            wn <= s ? 8'h19 : 8'h00;
            for (int i = 0; i < 13; i++) begin
                run(cw(to[i][4:1], to[i][0], 5'h05), {40'h0, te[i]}, tn[i]);
            end
        end
        chk({far.rmt, far.lock}, 2'b11);
        run(cw(4'h7, 1'b0, 5'h05), 64'h0, 0);
        st(32'h03);
        chk({far.rmt, far.lock}, 2'b00);
        run(cw(4'h5, 1'b0, 5'h05), 64'h0, 0);
        st(32'h13);
        run(cw(4'hc, 1'b0, 5'h05), 64'h0, 0);
        rd_r(REG_RESULT);
        chk(v, 32'ha6);
        run(cw(4'hd, 1'b0, 5'h05), 64'h3f453e18195f, 6);
        rd_r(REG_RESULT);
        chk(v, 32'h41);
        run(cw(4'ha, 1'b1, 5'h05), 64'h0, 0);
        st(32'h1b);
        wr_r(REG_STATUS, 32'h08);
        run(cw(4'hf, 1'b0, 5'h05), 64'h0, 0);
        st(32'h1b);
        wr_r(REG_STATUS, 32'h08);
        run(cw(4'hb, 1'b0, 5'h05), 64'h4509, 2);
        st(32'h11);
        run(cw(4'h0, 1'b0, 5'h05), 64'h0, 0);
        st(32'h19);
        wr_r(REG_STATUS, 32'h08);
        run(cw(4'ha, 1'b0, 5'h05), 64'h0, 0);
        st(32'h13);
        // abort lands while a stalled byte is still pending
        wn <= 8'hc8;
        q.delete();
        wr_r(REG_CMD, cw(4'h0, 1'b0, 5'h05));
        repeat (150) @(posedge sys_clk);
        wr_r(REG_CMD, cw(4'ha, 1'b0, 5'h05));
        idle();
        chk(q.size(), 0);
        st(32'h13);
        test_done();
    end
    initial begin
        #1000000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
